// File: rtl/acc_ops_pkg.sv
// shared constants and types for the accumulator logic/move/rotate unit
package acc_ops_pkg;
  localparam int unsigned DATA_WIDTH    = 8;
  localparam int unsigned FILE_AW       = 7;
  localparam int unsigned FILE_DEPTH    = 128;
  localparam int unsigned PC_WIDTH      = 13;
  localparam int unsigned BUS_AW        = 8;
  // register bus map
  localparam logic [7:0]  ADDR_FILE_LAST = 8'h7F;
  localparam logic [7:0]  ADDR_ACC       = 8'h80;
  localparam logic [7:0]  ADDR_STATUS    = 8'h81;
  localparam logic [7:0]  ADDR_CONTROL   = 8'h82;
  localparam logic [7:0]  ADDR_PC_LOW    = 8'h83;
  localparam logic [7:0]  ADDR_PC_HIGH   = 8'h84;
  // field positions
  localparam int unsigned STATUS_CARRY_BIT = 0;
  localparam int unsigned STATUS_ZERO_BIT  = 2;
  localparam int unsigned CONTROL_GIE_BIT  = 0;
  // reset values and pc increment
  localparam logic [7:0]  ACC_RESET      = 8'h00;
  localparam logic [7:0]  FILE_RESET     = 8'h00;
  localparam logic [12:0] PC_RESET       = 13'h0000;
  localparam logic [12:0] PC_STEP        = 13'h0001;

  typedef enum logic [2:0] {
    no_operation              = 3'b000,
    or_literal_into_acc       = 3'b001,
    load_literal_into_acc     = 3'b010,
    or_acc_with_file          = 3'b011,
    store_acc_to_file         = 3'b100,
    move_file_value           = 3'b101,
    rotate_left_through_carry = 3'b110,
    return_from_interrupt     = 3'b111
  } op_type;

  typedef struct packed {
    op_type       op;
    logic [7:0]   literal;
    logic [6:0]   file_addr;
    logic         dest_file;
  } instr_type;

  typedef struct packed {
    logic [7:0]   addr;
    logic [7:0]   wr_data;
    logic         wr_en;
    logic         rd_en;
  } bus_req_type;
endpackage

// File: rtl/acc_ops_unit.sv
// execution unit for or, move, no-op, return-from-interrupt and rotate-left
//
// Behaviour
// - or literal into acc, zero flag only
// - load literal into acc, flags untouched
// - or acc with file, dest bit selects
// - store acc to file, flags untouched
// - move file value to acc or file
// - move file sets zero flag either destination
// - rotate left through carry, carry only
// - rotate result to acc or file by dest
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module acc_ops_unit
(
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic                    instr_valid,
  input  wire acc_ops_pkg::instr_type  instr,
  input  wire logic [12:0]             return_stack_top,
  output logic                         stack_pop,
  output logic [12:0]                  pc_q,
  output logic                         global_interrupt_enable_bit_q,
  output logic [7:0]                   acc_q,
  output logic                         carry_q,
  output logic                         zero_q,
  input  wire acc_ops_pkg::bus_req_type bus_req,
  output logic [7:0]                   rd_data_q
);

  logic [7:0]  file_q [acc_ops_pkg::FILE_DEPTH];
  logic [7:0]  file_d [acc_ops_pkg::FILE_DEPTH];
  logic [7:0]  acc_d;
  logic        carry_d;
  logic        zero_d;
  logic        gie_d;
  logic [12:0] pc_d;
  logic [7:0]  rd_data_d;
  logic [7:0]  file_val;
  logic [7:0]  result;
  logic        bus_wr;

  function automatic logic is_file_addr(input logic [7:0] a);
    return a <= acc_ops_pkg::ADDR_FILE_LAST;
  endfunction

  // operand path; literal taken whole, encoder keeps spare bits zero
  assign file_val  = file_q[instr.file_addr];
  // handshake to the stack owner, same cycle as the return
  assign stack_pop = instr_valid && (instr.op == acc_ops_pkg::return_from_interrupt);
  // an executing instruction owns the state; a bus write in that cycle is dropped
  assign bus_wr    = bus_req.wr_en && !instr_valid;

  always_comb
  begin
    file_d  = file_q;
    acc_d   = acc_q;
    carry_d = carry_q;
    zero_d  = zero_q;
    gie_d   = global_interrupt_enable_bit_q;
    pc_d    = pc_q;
    result  = 8'h00;
    if (instr_valid)
    begin
      pc_d = pc_q + acc_ops_pkg::PC_STEP;
      unique case (instr.op)
        acc_ops_pkg::no_operation:
        begin
          result = 8'h00;
        end
        acc_ops_pkg::or_literal_into_acc:
        begin
          result = acc_q | instr.literal;
          acc_d  = result;
          zero_d = (result == 8'h00);
        end
        acc_ops_pkg::load_literal_into_acc:
        begin
          acc_d = instr.literal;
        end
        acc_ops_pkg::or_acc_with_file:
        begin
          result = acc_q | file_val;
          zero_d = (result == 8'h00);
          if (instr.dest_file)
            file_d[instr.file_addr] = result;
          else
            acc_d = result;
        end
        acc_ops_pkg::store_acc_to_file:
        begin
          file_d[instr.file_addr] = acc_q;
        end
        acc_ops_pkg::move_file_value:
        begin
          result = file_val;
          zero_d = (result == 8'h00);
          if (!instr.dest_file)
            acc_d = result;
        end
        acc_ops_pkg::rotate_left_through_carry:
        begin
          result  = {file_val[6:0], carry_q};
          carry_d = file_val[7];
          if (instr.dest_file)
            file_d[instr.file_addr] = result;
          else
            acc_d = result;
        end
        acc_ops_pkg::return_from_interrupt:
        begin
          pc_d  = return_stack_top;
          gie_d = 1'b1;
        end
      endcase
    end
    else if (bus_wr)
    begin
      if (is_file_addr(bus_req.addr))
        file_d[bus_req.addr[6:0]] = bus_req.wr_data;
      else if (bus_req.addr == acc_ops_pkg::ADDR_ACC)
        acc_d = bus_req.wr_data;
      else if (bus_req.addr == acc_ops_pkg::ADDR_STATUS)
      begin
        carry_d = bus_req.wr_data[acc_ops_pkg::STATUS_CARRY_BIT];
        zero_d  = bus_req.wr_data[acc_ops_pkg::STATUS_ZERO_BIT];
      end
      else if (bus_req.addr == acc_ops_pkg::ADDR_CONTROL)
        gie_d = bus_req.wr_data[acc_ops_pkg::CONTROL_GIE_BIT];
    end
  end

  always_comb
  begin
    rd_data_d = 8'h00;
    if (bus_req.rd_en)
    begin
      if (is_file_addr(bus_req.addr))
        rd_data_d = file_q[bus_req.addr[6:0]];
      else if (bus_req.addr == acc_ops_pkg::ADDR_ACC)
        rd_data_d = acc_q;
      else if (bus_req.addr == acc_ops_pkg::ADDR_STATUS)
      begin
        rd_data_d[acc_ops_pkg::STATUS_CARRY_BIT] = carry_q;
        rd_data_d[acc_ops_pkg::STATUS_ZERO_BIT]  = zero_q;
      end
      else if (bus_req.addr == acc_ops_pkg::ADDR_CONTROL)
        rd_data_d[acc_ops_pkg::CONTROL_GIE_BIT] = global_interrupt_enable_bit_q;
      else if (bus_req.addr == acc_ops_pkg::ADDR_PC_LOW)
        rd_data_d = pc_q[7:0];
      else if (bus_req.addr == acc_ops_pkg::ADDR_PC_HIGH)
        rd_data_d = {3'h0, pc_q[12:8]};
    end
  end

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < acc_ops_pkg::FILE_DEPTH; i++)
        file_q[i] <= acc_ops_pkg::FILE_RESET;
      acc_q                         <= acc_ops_pkg::ACC_RESET;
      carry_q                       <= 1'b0;
      zero_q                        <= 1'b0;
      global_interrupt_enable_bit_q <= 1'b0;
      pc_q                          <= acc_ops_pkg::PC_RESET;
      rd_data_q                     <= 8'h00;
    end
    else
    begin
      file_q                        <= file_d;
      acc_q                         <= acc_d;
      carry_q                       <= carry_d;
      zero_q                        <= zero_d;
      global_interrupt_enable_bit_q <= gie_d;
      pc_q                          <= pc_d;
      rd_data_q                     <= rd_data_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  logic ex_or_lit, ex_ld_lit, ex_or_file, ex_store, ex_move, ex_rot, ex_nop, ex_ret;
  assign ex_or_lit  = instr_valid && instr.op == acc_ops_pkg::or_literal_into_acc;
  assign ex_ld_lit  = instr_valid && instr.op == acc_ops_pkg::load_literal_into_acc;
  assign ex_or_file = instr_valid && instr.op == acc_ops_pkg::or_acc_with_file;
  assign ex_store   = instr_valid && instr.op == acc_ops_pkg::store_acc_to_file;
  assign ex_move    = instr_valid && instr.op == acc_ops_pkg::move_file_value;
  assign ex_rot     = instr_valid && instr.op == acc_ops_pkg::rotate_left_through_carry;
  assign ex_nop     = instr_valid && instr.op == acc_ops_pkg::no_operation;
  assign ex_ret     = instr_valid && instr.op == acc_ops_pkg::return_from_interrupt;

  or_literal_a: assert property (ex_or_lit |=> acc_q == ($past(acc_q) | $past(instr.literal))
    && zero_q == (acc_q == 8'h00) && $stable(carry_q))
    else $error("or literal result or flags wrong");
  load_literal_a: assert property (ex_ld_lit |=> acc_q == $past(instr.literal)
    && $stable(carry_q) && $stable(zero_q))
    else $error("load literal wrong or flags moved");
  or_file_a: assert property (ex_or_file && instr.dest_file |=>
    file_q[$past(instr.file_addr)] == ($past(acc_q) | $past(file_val)) && $stable(acc_q))
    else $error("or with file to file wrong");
  store_acc_a: assert property (ex_store |=> file_q[$past(instr.file_addr)] == acc_q
    && $stable(zero_q) && $stable(carry_q))
    else $error("store acc wrong");
  move_file_a: assert property (ex_move |=> zero_q == ($past(file_val) == 8'h00)
    && file_q[$past(instr.file_addr)] == $past(file_val))
    else $error("move file zero flag or contents wrong");
  move_to_acc_a: assert property (ex_move && !instr.dest_file |=>
    acc_q == $past(file_val) && $stable(carry_q))
    else $error("move file to acc wrong");
  rotate_to_file_a: assert property (ex_rot && instr.dest_file |=>
    file_q[$past(instr.file_addr)] == {$past(file_val[6:0]), $past(carry_q)}
    && carry_q == $past(file_val[7]) && $stable(acc_q))
    else $error("rotate left into file wrong");
  rotate_acc_a: assert property (ex_rot && !instr.dest_file |=>
    acc_q == {$past(file_val[6:0]), $past(carry_q)} && carry_q == $past(file_val[7])
    && $stable(zero_q))
    else $error("rotate left wrong");
  no_op_a: assert property (ex_nop |=> pc_q == $past(pc_q) + acc_ops_pkg::PC_STEP
    && $stable(acc_q) && $stable(zero_q) && $stable(carry_q))
    else $error("no-op changed state");
  return_restore_a: assert property (ex_ret |-> stack_pop ##1 pc_q == $past(return_stack_top)
    && global_interrupt_enable_bit_q && $stable(zero_q))
    else $error("return did not restore pc and gie");

  rotate_to_file_c: cover property (ex_rot && instr.dest_file && file_val[7]);
  move_zero_test_c: cover property (ex_move && instr.dest_file && file_val == 8'h00);
  return_after_or_c: cover property (ex_or_file ##1 ex_ret);

endmodule // acc_ops_unit

// File: testbench/test_accumulator_logic_move_rotate_ops.sv
// self-checking bench for the accumulator or/move/rotate execution unit
`timescale 1ns/1ps
module test_accumulator_logic_move_rotate_ops;
  logic                     clk_sys;
  logic                     reset;
  logic                     instr_valid;
  acc_ops_pkg::instr_type   instr;
  logic [12:0]              return_stack_top;
  logic                     stack_pop;
  logic [12:0]              pc_q;
  logic                     global_interrupt_enable_bit_q;
  logic [7:0]               acc_q;
  logic                     carry_q;
  logic                     zero_q;
  acc_ops_pkg::bus_req_type bus_req;
  logic [7:0]               rd_data_q;
  logic [7:0]               mf [128];
  logic [7:0]               m_acc;
  logic                     m_c;
  logic                     m_z;
  logic                     m_gie;
  logic [12:0]              m_pc;
  logic [31:0]              rnd;
  int                       failures;
  int                       total_checks;

  acc_ops_unit dut_u
  (
    .clk_sys                       (clk_sys),
    .reset                         (reset),
    .instr_valid                   (instr_valid),
    .instr                         (instr),
    .return_stack_top              (return_stack_top),
    .stack_pop                     (stack_pop),
    .pc_q                          (pc_q),
    .global_interrupt_enable_bit_q (global_interrupt_enable_bit_q),
    .acc_q                         (acc_q),
    .carry_q                       (carry_q),
    .zero_q                        (zero_q),
    .bus_req                       (bus_req),
    .rd_data_q                     (rd_data_q)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic wrap_up();
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // {carry, result} of one operation, carry is the old one unless rotating
  function automatic logic [8:0] alu(acc_ops_pkg::op_type op, logic [7:0] a, logic [7:0] f,
                                     logic [7:0] k, logic c);
    case (op)
      acc_ops_pkg::or_literal_into_acc:       return {c, a | k};
      acc_ops_pkg::load_literal_into_acc:     return {c, k};
      acc_ops_pkg::or_acc_with_file:          return {c, a | f};
      acc_ops_pkg::move_file_value:           return {c, f};
      acc_ops_pkg::rotate_left_through_carry: return {f[7], f[6:0], c};
      default:                                return {c, a};
    endcase
  endfunction

  function automatic logic [7:0] exp_rd(logic [7:0] a);
    if (a <= 8'h7F) return mf[a[6:0]];
    case (a)
      8'h80:   return m_acc;
      8'h81:   return {5'h00, m_z, 1'b0, m_c};
      8'h82:   return {7'h00, m_gie};
      8'h83:   return m_pc[7:0];
      8'h84:   return {3'h0, m_pc[12:8]};
      default: return 8'h00;
    endcase
  endfunction

  task automatic model_reset();
    for (int i = 0; i < 128; i++) mf[i] = 8'h00;
    m_acc = 8'h00; m_c = 1'b0; m_z = 1'b0; m_gie = 1'b0; m_pc = 13'h0000;
  endtask

  // state seen one step after the edge that took the previous request
  task automatic cmp_state();
    #1;
    check(acc_q, m_acc);
    check(carry_q, m_c);
    check(zero_q, m_z);
    check(pc_q, m_pc);
    check(global_interrupt_enable_bit_q, m_gie);
  endtask

  task automatic do_reset(input int n);
    @(posedge clk_sys);
    reset <= 1'b1; instr_valid <= 1'b0; bus_req <= '0;
    repeat (n) @(posedge clk_sys);
    reset <= 1'b0;
    model_reset();
  endtask

  // bus write beside an instruction is dropped, so the model ignores br
  task automatic run(acc_ops_pkg::op_type op, logic [7:0] k, logic [6:0] fa, logic d,
                     acc_ops_pkg::bus_req_type br);
    logic [8:0]  r;
    logic [12:0] top;
    top = 13'($urandom);
    // the encoder leaves the unused fields of a literal load at zero
    if (op == acc_ops_pkg::load_literal_into_acc)
    begin
      fa = 7'h00;
      d  = 1'b0;
    end
    @(posedge clk_sys);
    instr_valid <= 1'b1; instr <= '{op, k, fa, d}; bus_req <= br; return_stack_top <= top;
    cmp_state();
    check(stack_pop, op == acc_ops_pkg::return_from_interrupt);
    r = alu(op, m_acc, mf[fa], k, m_c);
    case (op)
      acc_ops_pkg::or_literal_into_acc:   begin m_acc = r[7:0]; m_z = (r[7:0] == 8'h00); end
      acc_ops_pkg::load_literal_into_acc: m_acc = r[7:0];
      acc_ops_pkg::store_acc_to_file:     mf[fa] = m_acc;
      acc_ops_pkg::or_acc_with_file, acc_ops_pkg::move_file_value,
      acc_ops_pkg::rotate_left_through_carry:
      begin
        if (op == acc_ops_pkg::rotate_left_through_carry) m_c = r[8];
        else m_z = (r[7:0] == 8'h00);
        if (d) mf[fa] = r[7:0];
        else m_acc = r[7:0];
      end
      acc_ops_pkg::return_from_interrupt: m_gie = 1'b1;
      default: ;
    endcase
    m_pc = (op == acc_ops_pkg::return_from_interrupt) ? top : m_pc + 13'h0001;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    instr_valid <= 1'b0; bus_req <= '{a, v, 1'b1, 1'b0};
    cmp_state();
    if (a <= 8'h7F) mf[a[6:0]] = v;
    else if (a == 8'h80) m_acc = v;
    else if (a == 8'h81) begin m_c = v[0]; m_z = v[2]; end
    else if (a == 8'h82) m_gie = v[0];
  endtask

  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    @(posedge clk_sys);
    instr_valid <= 1'b0; bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    cmp_state();
    e = exp_rd(a);
    @(posedge clk_sys);
    bus_req <= '0;
    cmp_state();
    check(rd_data_q, e);
  endtask

  task automatic readback();
    for (int i = 0; i <= 132; i++) rd(8'(i));
    rd(8'hC3);
  endtask

  initial
  begin
    #40000;
    failures++;
    wrap_up();
  end

  initial
  begin
    reset = 1'b1; instr_valid = 1'b0; instr = '0; return_stack_top = 13'h0000; bus_req = '0;
    failures = 0; total_checks = 0;
    model_reset();
    void'($urandom(32'haf63));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    readback();
    run(acc_ops_pkg::load_literal_into_acc, 8'h00, 7'h00, 1'b0, '0);
    run(acc_ops_pkg::or_literal_into_acc, 8'h00, 7'h00, 1'b0, '0);
    run(acc_ops_pkg::or_literal_into_acc, 8'hFF, 7'h00, 1'b1, '0);
    run(acc_ops_pkg::store_acc_to_file, 8'h00, 7'h7F, 1'b0, '0);
    run(acc_ops_pkg::rotate_left_through_carry, 8'h00, 7'h7F, 1'b1, '0);
    run(acc_ops_pkg::move_file_value, 8'h00, 7'h00, 1'b1, '0);
    run(acc_ops_pkg::return_from_interrupt, 8'h00, 7'h00, 1'b0, '0);
    wr(8'h83, 8'h5A);
    wr(8'h84, 8'h1F);
    wr(8'h81, 8'h05);
    for (int i = 0; i < 16; i++)
    begin
      rnd = $urandom;
      run(acc_ops_pkg::op_type'(i[3:1]), rnd[7:0], rnd[14:8], i[0], '0);
    end
    repeat (600)
    begin
      rnd = $urandom;
      case (rnd[31:29])
        3'h0:    run(acc_ops_pkg::op_type'(rnd[2:0]), rnd[10:3], rnd[17:11], rnd[18],
                     '{{1'b0, rnd[25:19]}, rnd[7:0], 1'b1, 1'b0});
        3'h1:    wr(rnd[7:0], rnd[15:8]);
        3'h2:    rd(rnd[7:0]);
        default: run(acc_ops_pkg::op_type'(rnd[2:0]), rnd[10:3], rnd[17:11], rnd[18], '0);
      endcase
    end
    readback();
    do_reset(2);
    readback();
    wrap_up();
  end
endmodule // test_accumulator_logic_move_rotate_ops
